/* verilog/dsr_pkg.sv */
package dsr_pkg;
    localparam logic [7:0] REG_STATUS1_ADDR = 8'h00;
    localparam logic [7:0] REG_STATUS2_ADDR = 8'h01;
    localparam logic [7:0] REG_VOLTAGE_ADDR = 8'h02;
    localparam logic [7:0] REG_TONE_ADDR    = 8'h03;
    localparam logic [7:0] REG_LIMIT_ADDR   = 8'h04;
    localparam logic [7:0] REG_LAST_ADDR    = 8'h04;
    localparam logic [7:0] REG_RESET_VAL    = 8'h00;
    localparam logic [7:0] TONE_WR_MASK     = 8'h55;
    localparam logic [7:0] LIMIT_WR_MASK    = 8'h44;
    localparam logic [6:0] DEF_CHIP_ADDR    = 7'h08;
    localparam int unsigned VSEL_A_LSB      = 0;
    localparam int unsigned VSEL_B_LSB      = 4;
    localparam int unsigned TONE_ON_A_BIT   = 0;
    localparam int unsigned TONE_SRC_A_BIT  = 2;
    localparam int unsigned TONE_ON_B_BIT   = 4;
    localparam int unsigned TONE_SRC_B_BIT  = 6;
    localparam int unsigned PLIM_A_BIT      = 2;
    localparam int unsigned PLIM_B_BIT      = 6;
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
    localparam int unsigned SYS_CLK_MHZ     = 100;
    localparam int unsigned SCL_HALF_NS     = 2500;
    localparam int unsigned SCL_HALF_CYC    = (SCL_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] HOST_ST_IDLE     = 8'h00;
    localparam logic [7:0] HOST_ST_ADDR     = 8'h04;
    localparam logic [7:0] HOST_ST_NACK     = 8'h08;
    localparam logic [7:0] HOST_ST_RDDATA   = 8'h0c;
    localparam logic [7:0] HOST_REG_CMD     = 8'h00;
    localparam logic [7:0] HOST_REG_STATUS  = 8'h04;
    localparam logic [7:0] HOST_REG_DATA    = 8'h08;
    localparam int unsigned CMD_GO_BIT      = 0;
    localparam int unsigned CMD_RD_BIT      = 1;
endpackage : dsr_pkg

/* verilog/dsr_link_if.sv */
`timescale 1ns/1ps
interface dsr_link_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda;
    // Open drain with pull-up: low wins
    assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
    modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface : dsr_link_if

/* verilog/dsr_device.sv */
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - Master releases SDA during acknowledge pulse.
// - Device holds SDA low through ack.
// - No ack leaves SDA high; STOP aborts.
// - Undervoltage lockout suppresses every acknowledge.
// - Master may ignore acknowledge bits.
// - Write: START, address, register, data.
// - Data bytes go to incrementing registers.
// - Write continues until STOP seen.
// - Device acks address, register, data bytes.
// - Read: set pointer, STOP, then read.
// - Send addressed register, next on ack.
// - Master nack then STOP; release SDA.
// - Access may start at any register.
// - Data registers read back last write.
// - Voltage register: two nibble selects.
// - Tone enable bits 0 and 4.
// - Tone source select bits 2 and 6.
// - Pulsed limit off bits 2 and 6.
// - Master writes zero to reserved bits.
// - Control registers clear on reset.
// - Bytes MSB first, each acknowledged.
// - STOP precedes every START.
module dsr_device
    import dsr_pkg::*;
#(
    parameter logic [6:0] CHIP_ADDR = DEF_CHIP_ADDR
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    dsr_link_if.device      link,
    input  wire logic       uvlo_i,
    input  wire logic [7:0] status1_i,
    input  wire logic [7:0] status2_i,
    output logic      [3:0] voltage_sel_a_o,
    output logic      [3:0] voltage_sel_b_o,
    output logic            tone_on_a_o,
    output logic            tone_on_b_o,
    output logic            tone_source_sel_a_o,
    output logic            tone_source_sel_b_o,
    output logic            pulsed_limit_off_a_o,
    output logic            pulsed_limit_off_b_o
);
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_RECV  = 5'b00010,
        S_ACK   = 5'b00100,
        S_SEND  = 5'b01000,
        S_MACK  = 5'b10000
    } dsr_dev_state_e;

    dsr_dev_state_e state_q;
    logic [2:0] scl_s_q, sda_s_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic [1:0] byte_idx_q;
    logic       rd_mode_q;
    logic [7:0] ptr_q;
    logic [7:0] volt_q, tone_q, limit_q;
    logic       sda_o_q, sda_oe_q;
    // Lockout comes from the supply monitor, outside this clock's domain
    logic [1:0] uvlo_s_q;
    logic [7:0] rd_byte_w;

    // Taps 1 and 2 only: tap 0 is the metastable stage
    wire scl_rise = scl_s_q[1] && !scl_s_q[2];
    wire scl_fall = !scl_s_q[1] && scl_s_q[2];
    wire start_c  = scl_s_q[1] && scl_s_q[2] && !sda_s_q[1] && sda_s_q[2];
    wire stop_c   = scl_s_q[1] && scl_s_q[2] && sda_s_q[1] && !sda_s_q[2];

    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] s1,
                                            input logic [7:0] s2, input logic [7:0] v,
                                            input logic [7:0] t, input logic [7:0] l);
        case (a)
            REG_STATUS1_ADDR: reg_read = s1;
            REG_STATUS2_ADDR: reg_read = s2;
            REG_VOLTAGE_ADDR: reg_read = v;
            REG_TONE_ADDR:    reg_read = t;
            REG_LIMIT_ADDR:   reg_read = l;
            default:          reg_read = REG_RESET_VAL;
        endcase
    endfunction : reg_read

    assign rd_byte_w = reg_read(ptr_q, status1_i, status2_i, volt_q, tone_q, limit_q);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_s_q  <= 3'h7;
            sda_s_q  <= 3'h7;
            uvlo_s_q <= 2'h0;
        end else begin
            scl_s_q  <= {scl_s_q[1:0], link.scl};
            sda_s_q  <= {sda_s_q[1:0], link.sda};
            uvlo_s_q <= {uvlo_s_q[0], uvlo_i};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q    <= S_IDLE;
            shift_q    <= 8'h00;
            bit_cnt_q  <= 4'h0;
            byte_idx_q <= 2'h0;
            rd_mode_q  <= 1'b0;
            ptr_q      <= 8'h00;
            volt_q     <= REG_RESET_VAL;
            tone_q     <= REG_RESET_VAL;
            limit_q    <= REG_RESET_VAL;
            sda_o_q    <= 1'b1;
            sda_oe_q   <= 1'b0;
        end else if (start_c) begin
            state_q    <= S_RECV;
            bit_cnt_q  <= 4'h0;
            byte_idx_q <= 2'h0;
            sda_oe_q   <= 1'b0;
        end else if (stop_c) begin
            state_q  <= S_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                S_RECV: begin
                    if (scl_rise) begin
                        shift_q   <= {shift_q[6:0], sda_s_q[1]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
                        bit_cnt_q <= 4'h0;
                        if (byte_idx_q == 2'h0) begin
                            rd_mode_q <= shift_q[0];
                            if (shift_q[7:1] != CHIP_ADDR || uvlo_s_q[1]) begin
                                state_q <= S_IDLE;
                            end else begin
                                state_q  <= S_ACK;
                                sda_o_q  <= 1'b0;
                                sda_oe_q <= 1'b1;
                            end
                        end else if (uvlo_s_q[1]) begin
                            state_q <= S_IDLE;
                        end else begin
                            if (byte_idx_q == 2'h1) begin
                                ptr_q <= shift_q;
                            end else begin
                                case (ptr_q)
                                    REG_VOLTAGE_ADDR: volt_q  <= shift_q;
                                    REG_TONE_ADDR:    tone_q  <= shift_q;
                                    REG_LIMIT_ADDR:   limit_q <= shift_q;
                                    default:          ;
                                endcase
                                ptr_q <= ptr_q + 8'h01;
                            end
                            state_q  <= S_ACK;
                            sda_o_q  <= 1'b0;
                            sda_oe_q <= 1'b1;
                        end
                        if (byte_idx_q != 2'h2) begin
                            byte_idx_q <= byte_idx_q + 2'h1;
                        end
                    end
                end
                S_ACK: begin
                    // Held low from SCL low before ack to SCL low after it
                    if (scl_fall) begin
                        if (rd_mode_q && byte_idx_q == 2'h1) begin
                            state_q  <= S_SEND;
                            shift_q  <= rd_byte_w;
                            sda_o_q  <= rd_byte_w[7];
                            ptr_q    <= ptr_q + 8'h01;
                            bit_cnt_q <= 4'h1;
                        end else begin
                            state_q  <= S_RECV;
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                S_SEND: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == BITS_PER_BYTE) begin
                            state_q  <= S_MACK;
                            sda_oe_q <= 1'b0;
                        end else begin
                            sda_o_q   <= shift_q[7 - bit_cnt_q[2:0]];
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        rd_mode_q <= !sda_s_q[1]; // Ack low asks for more
                    end else if (scl_fall) begin
                        if (rd_mode_q) begin
                            state_q   <= S_SEND;
                            shift_q   <= rd_byte_w;
                            sda_o_q   <= rd_byte_w[7];
                            sda_oe_q  <= 1'b1;
                            ptr_q     <= ptr_q + 8'h01;
                            bit_cnt_q <= 4'h1;
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    assign link.sda_dev_o  = sda_o_q;
    assign link.sda_dev_oe = sda_oe_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            voltage_sel_a_o      <= 4'h0;
            voltage_sel_b_o      <= 4'h0;
            tone_on_a_o          <= 1'b0;
            tone_on_b_o          <= 1'b0;
            tone_source_sel_a_o  <= 1'b0;
            tone_source_sel_b_o  <= 1'b0;
            pulsed_limit_off_a_o <= 1'b0;
            pulsed_limit_off_b_o <= 1'b0;
        end else begin
            voltage_sel_a_o      <= volt_q[VSEL_A_LSB +: 4];
            voltage_sel_b_o      <= volt_q[VSEL_B_LSB +: 4];
            tone_on_a_o          <= tone_q[TONE_ON_A_BIT];
            tone_on_b_o          <= tone_q[TONE_ON_B_BIT];
            tone_source_sel_a_o  <= tone_q[TONE_SRC_A_BIT];
            tone_source_sel_b_o  <= tone_q[TONE_SRC_B_BIT];
            pulsed_limit_off_a_o <= limit_q[PLIM_A_BIT];
            pulsed_limit_off_b_o <= limit_q[PLIM_B_BIT];
        end
    end
endmodule : dsr_device

/* verilog/dsr_host.sv */
`timescale 1ns/1ps
module dsr_host
    import dsr_pkg::*;
#(
    parameter logic [6:0] CHIP_ADDR = DEF_CHIP_ADDR,
    parameter int unsigned HALF_CYC = SCL_HALF_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    dsr_link_if.host        link,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o
);
    // Host command: GO bit starts, RD bit selects single-byte read
    // Write: START, chip addr W, register, one data byte, STOP
    // Read: START, chip addr W, register, STOP, START, chip addr R, byte, nack, STOP
    typedef enum logic [3:0] {
        H_IDLE  = 4'b0001,
        H_START = 4'b0010,
        H_BITS  = 4'b0100,
        H_STOP  = 4'b1000
    } dsr_host_state_e;

    dsr_host_state_e state_q;
    logic [7:0]  regnum_q, wdata_q, rxd_q, shift_q;
    logic        rd_q, busy_q, nack_q, scl_q, sda_o_q;
    logic [1:0]  seq_q;
    logic [3:0]  bit_q;
    logic [1:0]  phase_q;
    logic [15:0] tick_q;
    logic [2:0]  sda_s_q;
    logic        rd_sel_q;

    wire tick = (tick_q == 16'(HALF_CYC - 1));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_s_q <= 3'h7;
        end else begin
            sda_s_q <= {sda_s_q[1:0], link.sda};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_q <= 16'h0000;
        end else begin
            tick_q <= (tick || state_q == H_IDLE) ? 16'h0000 : tick_q + 16'h0001;
        end
    end

    // Byte sent in transfer step: 0 addrW, 1 reg, 2 addrR, 3 data or read byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q  <= H_IDLE;
            regnum_q <= 8'h00;
            wdata_q  <= 8'h00;
            rxd_q    <= 8'h00;
            shift_q  <= 8'hff;
            rd_q     <= 1'b0;
            busy_q   <= 1'b0;
            nack_q   <= 1'b0;
            scl_q    <= 1'b1;
            sda_o_q  <= 1'b1;
            seq_q    <= 2'h0;
            bit_q    <= 4'h0;
            phase_q  <= 2'h0;
        end else begin
            case (state_q)
                H_IDLE: begin
                    if (wr_i && addr_i == HOST_ST_ADDR) begin
                        regnum_q <= wdata_i;
                    end else if (wr_i && addr_i == HOST_REG_DATA) begin
                        wdata_q <= wdata_i;
                    end else if (wr_i && addr_i == HOST_REG_CMD && wdata_i[CMD_GO_BIT]) begin
                        rd_q    <= wdata_i[CMD_RD_BIT];
                        busy_q  <= 1'b1;
                        nack_q  <= 1'b0;
                        seq_q   <= 2'h0;
                        state_q <= H_START;
                        phase_q <= 2'h0;
                    end
                end
                H_START: if (tick) begin
                    // START only after STOP leaves bus idle
                    if (phase_q == 2'h0) begin
                        sda_o_q <= 1'b0;
                        phase_q <= 2'h1;
                    end else begin
                        scl_q   <= 1'b0;
                        state_q <= H_BITS;
                        bit_q   <= 4'h0;
                        phase_q <= 2'h0;
                        shift_q <= (seq_q == 2'h2) ? {CHIP_ADDR, 1'b1} : {CHIP_ADDR, 1'b0};
                    end
                end
                H_BITS: if (tick) begin
                    if (!scl_q) begin
                        if (bit_q < BITS_PER_BYTE) begin
                            sda_o_q <= shift_q[7] || (rd_q && seq_q == 2'h3); // MSB first
                        end else begin
                            // Release for ack after every byte: after the read byte this is the nack that ends it
                            sda_o_q <= 1'b1;
                        end
                        scl_q <= 1'b1;
                    end else begin
                        scl_q <= 1'b0;
                        if (bit_q < BITS_PER_BYTE) begin
                            rxd_q   <= {rxd_q[6:0], sda_s_q[1]};
                            shift_q <= {shift_q[6:0], 1'b1};
                            bit_q   <= bit_q + 4'h1;
                        end else begin
                            if (sda_s_q[1] && !(rd_q && seq_q == 2'h3)) begin
                                nack_q  <= 1'b1;
                                state_q <= H_STOP;
                            end else if (seq_q == 2'h0) begin
                                seq_q   <= 2'h1;
                                bit_q   <= 4'h0;
                                shift_q <= regnum_q;
                            end else if (seq_q == 2'h1 && !rd_q) begin
                                seq_q   <= 2'h3;
                                bit_q   <= 4'h0;
                                shift_q <= wdata_q;
                            end else if (seq_q == 2'h2) begin
                                seq_q   <= 2'h3;
                                bit_q   <= 4'h0;
                                shift_q <= 8'hff;
                            end else begin
                                state_q <= H_STOP;
                            end
                            phase_q <= 2'h0;
                        end
                    end
                end
                H_STOP: if (tick) begin
                    if (phase_q == 2'h0) begin
                        sda_o_q <= 1'b0;
                        phase_q <= 2'h1;
                    end else if (phase_q == 2'h1) begin
                        scl_q   <= 1'b1;
                        phase_q <= 2'h2;
                    end else begin
                        sda_o_q <= 1'b1;
                        phase_q <= 2'h0;
                        if (rd_q && seq_q == 2'h1 && !nack_q) begin
                            seq_q   <= 2'h2;
                            state_q <= H_START;
                        end else begin
                            busy_q  <= 1'b0;
                            state_q <= H_IDLE;
                        end
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_sel_q <= 1'b0;
            rdata_o  <= 8'h00;
        end else begin
            rd_sel_q <= rd_i;
            if (rd_i) begin
                case (addr_i)
                    HOST_REG_STATUS: rdata_o <= {6'h00, nack_q, busy_q};
                    HOST_REG_DATA:   rdata_o <= rxd_q;
                    HOST_ST_ADDR:    rdata_o <= regnum_q;
                    default:         rdata_o <= 8'h00;
                endcase
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end

    assign link.scl         = scl_q;
    assign link.sda_host_o  = sda_o_q;
    assign link.sda_host_oe = !sda_o_q;
endmodule : dsr_host

/* sim/dsr_assertions.sv */
`timescale 1ns/1ps
module dsr_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] cnt_q;
    logic [1:0] nby_q;
    logic       start_w;
    logic       stop_w;
    assign start_w = scl && scl_q && sda_q && !sda;
    assign stop_w  = scl && scl_q && !sda_q && sda;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    // Pulses since START; the STOP pulse counts as pulse one of a new byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            nby_q <= 2'h0;
        end else if (start_w) begin
            cnt_q <= 4'h0;
            nby_q <= 2'h0;
        end else if (scl && !scl_q) begin
            cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
            if (cnt_q == 4'h9 && nby_q != 2'h3) begin
                nby_q <= nby_q + 2'h1;
            end
        end
    end
    dev_hold_a: assert property (scl && scl_q |-> $stable({sda_dev_oe, sda_dev_o}))
        else $error("device changed sda while scl high");
    no_fight_a: assert property (scl |-> !(sda_host_oe && sda_dev_oe))
        else $error("host and device drive sda together");
    hi_min_a: assert property ($rose(scl) |-> scl[*4])
        else $error("scl high phase too short");
    lo_min_a: assert property ($fell(scl) |-> !scl[*4])
        else $error("scl low phase too short");
    start_own_a: assert property (start_w |-> sda_host_oe && !sda_host_o && !sda_dev_oe)
        else $error("start not made by host alone");
    stop_free_a: assert property (stop_w |-> !sda_dev_oe[*4])
        else $error("device drives sda after stop");
    stop_place_a: assert property (stop_w |-> cnt_q == 4'h1)
        else $error("stop not after an acknowledge");
    addr_quiet_a: assert property (scl && scl_q && nby_q == 2'h0 && cnt_q != 4'h9
        |-> !sda_dev_oe) else $error("device drives during address bits");
    ack_c: cover property (scl && cnt_q == 4'h9 && !sda);
    nack_c: cover property (scl && scl_q && cnt_q == 4'h9 && sda);
    long_c: cover property (stop_w && nby_q == 2'h3);
endmodule : dsr_assertions

/* sim/dual_supply_i2c_slave_regs_tb.sv */
`timescale 1ns/1ps
module dual_supply_i2c_slave_regs_tb;
    import dsr_pkg::*;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] addr  = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic       uvlo  = 1'b0;
    logic [7:0] st1   = 8'h00;
    logic [7:0] st2   = 8'h00;
    logic [7:0] rdata;
    logic [3:0] vsa;
    logic [3:0] vsb;
    logic [5:0] ctl;
    int         err_total = 0;
    int         total_checks = 0;
    int         cyc = 0;
    always #5 clk_i = ~clk_i;
    dsr_link_if dsr_link_if_i ();
    dsr_host #(.HALF_CYC(8)) dsr_host_i (.clk_i(clk_i), .rst_i(rst_i), .link(dsr_link_if_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
    dsr_device dsr_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(dsr_link_if_i),
        .uvlo_i(uvlo), .status1_i(st1), .status2_i(st2), .voltage_sel_a_o(vsa),
        .voltage_sel_b_o(vsb), .tone_on_a_o(ctl[0]), .tone_source_sel_a_o(ctl[1]),
        .tone_on_b_o(ctl[2]), .tone_source_sel_b_o(ctl[3]),
        .pulsed_limit_off_a_o(ctl[4]), .pulsed_limit_off_b_o(ctl[5]));
    dsr_assertions dsr_assertions_i (.clk_i(clk_i), .rst_i(rst_i), .scl(dsr_link_if_i.scl),
        .sda_host_o(dsr_link_if_i.sda_host_o), .sda_host_oe(dsr_link_if_i.sda_host_oe),
        .sda_dev_o(dsr_link_if_i.sda_dev_o), .sda_dev_oe(dsr_link_if_i.sda_dev_oe),
        .sda(dsr_link_if_i.sda));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s: got %h want %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge clk_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdata;
    endtask : bus
    // Busy only rises a cycle after GO, so polling starts two cycles later
    task automatic xfer(input logic r, input logic [7:0] n, input logic [7:0] d,
                        output logic [7:0] st, output logic [7:0] q);
        bus(1'b1, HOST_REG_STATUS, n, q);
        bus(1'b1, HOST_REG_DATA, d, q);
        bus(1'b1, HOST_REG_CMD, {6'h00, r, 1'b1}, q);
        repeat (2) @(posedge clk_i);
        st = 8'h01;
        for (int i = 0; i < 4000 && st[0] !== 1'b0; i++) bus(1'b0, HOST_REG_STATUS, 8'h00, st);
        bus(1'b0, HOST_REG_DATA, 8'h00, q);
        st = st & 8'h02;
    endtask : xfer
    task automatic t_reset;
        logic [7:0] st;
        logic [7:0] q;
        for (int a = 2; a <= 4; a++) begin
            xfer(1'b1, 8'(a), 8'h00, st, q);
            chk(q, REG_RESET_VAL, "reset value");
        end
        chk({2'b00, ctl}, 8'h00, "reset outputs");
        $display("test reset values done");
    endtask : t_reset
    task automatic t_regs;
        logic [7:0] st;
        logic [7:0] q;
        logic [7:0] v [3] = '{8'ha5, 8'h14, 8'h40};
        for (int a = 0; a < 3; a++) begin
            xfer(1'b0, 8'(a + 2), v[a], st, q);
            chk(st, 8'h00, "write ack");
        end
        for (int a = 0; a < 3; a++) begin
            xfer(1'b1, 8'(a + 2), 8'h00, st, q);
            chk(q, v[a], "read back");
        end
        chk({vsb, vsa}, 8'ha5, "voltage select");
        chk({2'b00, ctl}, 8'h26, "tone and limit bits");
        $display("test register access done");
    endtask : t_regs
    task automatic t_status;
        logic [7:0] st;
        logic [7:0] q;
        @(posedge clk_i);
        st1 <= 8'h3c;
        st2 <= 8'hc3;
        xfer(1'b1, REG_STATUS1_ADDR, 8'h00, st, q);
        chk(q, 8'h3c, "status one");
        xfer(1'b1, REG_STATUS2_ADDR, 8'h00, st, q);
        chk(q, 8'hc3, "status two");
        $display("test status read done");
    endtask : t_status
    task automatic t_unimpl;
        logic [7:0] st;
        logic [7:0] q;
        xfer(1'b0, 8'h07, 8'h5a, st, q);
        chk(st, 8'h00, "unmapped write ack");
        xfer(1'b1, 8'h07, 8'h00, st, q);
        chk(q, 8'h00, "unmapped read");
        xfer(1'b1, REG_VOLTAGE_ADDR, 8'h00, st, q);
        chk(q, 8'ha5, "no side write");
        $display("test unmapped done");
    endtask : t_unimpl
    task automatic t_uvlo;
        logic [7:0] st;
        logic [7:0] q;
        @(posedge clk_i);
        uvlo <= 1'b1;
        xfer(1'b0, REG_VOLTAGE_ADDR, 8'h33, st, q);
        chk(st, 8'h02, "lockout nack");
        @(posedge clk_i);
        uvlo <= 1'b0;
        xfer(1'b1, REG_VOLTAGE_ADDR, 8'h00, st, q);
        chk(q, 8'ha5, "lockout kept value");
        $display("test lockout done");
    endtask : t_uvlo
    task automatic t_rerst;
        logic [7:0] st;
        logic [7:0] q;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        xfer(1'b1, REG_VOLTAGE_ADDR, 8'h00, st, q);
        chk(q, 8'h00, "second reset");
        chk({vsb, vsa}, 8'h00, "second reset outputs");
        $display("test second reset done");
    endtask : t_rerst
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            $display("[ERR] %0t run too long", $time);
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_status();
        t_unimpl();
        t_uvlo();
        t_rerst();
        wrap_up();
    end
endmodule : dual_supply_i2c_slave_regs_tb
